// *** verilog/hmbo_pkg.sv ***
// Function
// - suspend low floats bus three cycles later
// - access stalls while suspend held low
// - suspend only for page fault, deadlock
// - host requests bus with active-low line
// - master yields bus, drives grant low
// - yielding means bus outputs float
// - host request beats all processor requests
// - grant held while host request held
// - only bus master drives host grant
// - host selects device with select line
// - ack low inserts host wait states
// - ack open drain until drive bit set
// - ack driven only with select and request
// - drive own request line, watch others
// - index n selects request line n
// - index zero means single processor
// - index changes only during reset
// - unused request lines held high
// - rotating priority when select high
package hmbo_pkg;
	localparam int NUM_PROC = 6;
	localparam int IDX_W = 3;
	localparam logic [IDX_W-1:0] IDX_SINGLE = 3'h0;
	localparam logic [NUM_PROC-1:0] REQ_IDLE = 6'h3f;
	typedef enum logic [1:0] {
		HMBO_IDLE = 2'h0,
		HMBO_REQ = 2'h1,
		HMBO_OWN = 2'h3,
		HMBO_HOST = 2'h2
	} hmbo_state_t;
endpackage : hmbo_pkg

// *** verilog/hmbo_if.sv ***
`timescale 1ns/1ns
`default_nettype none
interface hmbo_if;
	import hmbo_pkg::*;
	logic suspend_bus_float_n;
	logic host_request_n;
	logic host_select_n;
	logic host_grant_n_o;
	logic host_grant_n_oe;
	logic host_ack_o;
	logic host_ack_oe;
	logic [NUM_PROC-1:0] mp_request_n;
	logic [NUM_PROC-1:0] mp_request_n_o;
	logic [NUM_PROC-1:0] mp_request_n_oe;
	logic host_grant_n;
	logic host_ack;
	// wire levels resolved here: undriven lines pull high
	assign host_grant_n = host_grant_n_oe ? host_grant_n_o : 1'b1;
	assign host_ack = host_ack_oe ? host_ack_o : 1'b1;
	for (genvar i = 0; i < NUM_PROC; i++) begin : g_req
		assign mp_request_n[i] = mp_request_n_oe[i] ? mp_request_n_o[i] : 1'b1;
	end
	modport device (
		input suspend_bus_float_n, host_request_n, host_select_n,
		input mp_request_n, host_grant_n,
		output host_grant_n_o, host_grant_n_oe, host_ack_o, host_ack_oe,
		output mp_request_n_o, mp_request_n_oe
	);
	modport host (
		output suspend_bus_float_n, host_request_n, host_select_n,
		input host_grant_n, host_ack
	);
endinterface : hmbo_if
`default_nettype wire

// *** verilog/hmbo_device.sv ***
`timescale 1ns/1ns
`default_nettype none
module hmbo_device
	import hmbo_pkg::*;
(
	input wire logic CLK_SYS_IN,
	input wire logic RST_N_IN,
	hmbo_if.device BUS,
	input wire logic [IDX_W-1:0] PROCESSOR_INDEX_IN,
	input wire logic ROTATING_PRIORITY_SEL_IN,
	input wire logic ACK_ACTIVE_DRIVE_IN,
	input wire logic EXT_ACCESS_REQ_IN,
	input wire logic HOST_WAIT_IN,
	output logic EXT_ACCESS_DONE_OUT,
	output logic BUS_DRIVE_EN_OUT,
	output logic BUS_MASTER_OUT,
	output logic HOST_GRANTED_OUT
);
	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	typedef struct packed {
		logic [1:0] sb_sync;
		logic [1:0] hr_sync;
		logic [1:0] hs_sync;
		logic [NUM_PROC-1:0] br_s1;
		logic [NUM_PROC-1:0] br_s2;
		logic [NUM_PROC-1:0] br_s3;
		logic [1:0] hg_sync;
		logic [IDX_W-1:0] index;
		logic idx_loaded;
		logic rot;
		logic ack_drive;
		hmbo_state_t state;
		logic [IDX_W-1:0] last_owner;
		logic grant_n;
		logic grant_oe;
		logic ack;
		logic ack_oe;
		logic [NUM_PROC-1:0] req_o;
		logic [NUM_PROC-1:0] req_oe;
		logic done;
		logic drive;
		logic master;
		logic granted;
	} hmbo_dev_t;

	localparam hmbo_dev_t RESET_VAL = '{
		sb_sync: 2'h3, hr_sync: 2'h3, hs_sync: 2'h3,
		br_s1: REQ_IDLE, br_s2: REQ_IDLE, br_s3: REQ_IDLE, hg_sync: 2'h3,
		index: IDX_SINGLE,
		idx_loaded: 1'b0, rot: 1'b0, ack_drive: 1'b0, state: HMBO_IDLE,
		last_owner: IDX_SINGLE, grant_n: 1'b1, grant_oe: 1'b0,
		ack: 1'b1, ack_oe: 1'b0, req_o: REQ_IDLE, req_oe: '0,
		done: 1'b0, drive: 1'b0, master: 1'b0, granted: 1'b0
	};

	hmbo_dev_t r;
	hmbo_dev_t next_r;

	logic suspend;
	logic host_req;
	logic host_sel;
	logic single;
	logic [NUM_PROC-1:0] others_req;
	logic won;
	logic [IDX_W-1:0] cand;

	// ---------------------------------------------------------------
	// input sampling
	// ---------------------------------------------------------------
	// bus pins come from other chips, so each passes two flops
	always_comb begin
		next_r = r;
		next_r.sb_sync = {r.sb_sync[0], BUS.suspend_bus_float_n};
		next_r.hr_sync = {r.hr_sync[0], BUS.host_request_n};
		next_r.hs_sync = {r.hs_sync[0], BUS.host_select_n};
		next_r.br_s1 = BUS.mp_request_n;
		next_r.br_s2 = r.br_s1;
		next_r.br_s3 = r.br_s2;
		next_r.hg_sync = {r.hg_sync[0], BUS.host_grant_n};
		suspend = !r.sb_sync[1];
		host_req = !r.hr_sync[1];
		host_sel = !r.hs_sync[1];
		// ----------------------------------------
		// configuration
		// ----------------------------------------
		// index and mode latched once after reset release
		if (!r.idx_loaded) begin
			next_r.index = PROCESSOR_INDEX_IN;
			next_r.rot = ROTATING_PRIORITY_SEL_IN;
			next_r.ack_drive = ACK_ACTIVE_DRIVE_IN;
			next_r.idx_loaded = 1'b1;
		end
		single = (r.index == IDX_SINGLE);
		// others' requests; own line excluded
		others_req = ~r.br_s2;
		if (!single) begin
			others_req[r.index - 3'h1] = 1'b0;
		end
		// ----------------------------------------
		// arbitration
		// ----------------------------------------
		// fixed: lowest index wins; rotating: after last owner
		won = 1'b1;
		cand = IDX_SINGLE;
		for (int i = 1; i <= NUM_PROC; i++) begin
			if (r.rot) begin
				cand = IDX_W'((32'(r.last_owner) + i - 1) % NUM_PROC + 1);
			end else begin
				cand = IDX_W'(i);
			end
			if (cand == r.index) begin
				break;
			end
			if (others_req[cand - 3'h1]) begin
				won = 1'b0;
			end
		end
		// track who last held the bus for rotation
		// a released line marks the end of that owner's tenure
		for (int i = 0; i < NUM_PROC; i++) begin
			if (!r.br_s3[i] && r.br_s2[i]) begin
				next_r.last_owner = IDX_W'(i + 1);
			end
		end
		// ----------------------------------------
		// state machine
		// ----------------------------------------
		next_r.done = 1'b0;
		next_r.grant_oe = 1'b0;
		next_r.grant_n = 1'b1;
		unique case (r.state)
			HMBO_IDLE: begin
				if (host_req) begin
					next_r.state = HMBO_IDLE;
				end else if (EXT_ACCESS_REQ_IN && r.idx_loaded) begin
					next_r.state = single ? HMBO_OWN : HMBO_REQ;
				end
			end
			HMBO_REQ: begin
				if (host_req) begin
					next_r.state = HMBO_IDLE;
				// a granted host owns the bus: hold off until released
				end else if (won && r.hg_sync[1]) begin
					next_r.state = HMBO_OWN;
					next_r.last_owner = r.index;
				end
			end
			HMBO_OWN: begin
				if (host_req) begin
					next_r.state = HMBO_HOST;
				end else if (!EXT_ACCESS_REQ_IN) begin
					next_r.state = HMBO_IDLE;
				end else if (!suspend) begin
					next_r.done = 1'b1;
				end
			end
			HMBO_HOST: begin
				next_r.grant_oe = 1'b1;
				next_r.grant_n = 1'b0;
				if (!host_req) begin
					next_r.state = HMBO_IDLE;
					next_r.grant_oe = 1'b0;
					next_r.grant_n = 1'b1;
				end
			end
		endcase
		// ----------------------------------------
		// pin drive
		// ----------------------------------------
		// own request line only
		next_r.req_oe = '0;
		next_r.req_o = REQ_IDLE;
		if (!single) begin
			next_r.req_oe[r.index - 3'h1] = 1'b1;
			next_r.req_o[r.index - 3'h1] =
				!(next_r.state == HMBO_REQ || next_r.state == HMBO_OWN);
		end
		// float on suspend or while host holds the bus
		next_r.drive = (next_r.state == HMBO_OWN) && !suspend;
		next_r.master = (next_r.state == HMBO_OWN);
		next_r.granted = !next_r.grant_n;
		next_r.ack = !HOST_WAIT_IN;
		next_r.ack_oe = 1'b0;
		if (host_sel && host_req) begin
			next_r.ack_oe = r.ack_drive || HOST_WAIT_IN;
		end
	end

	// ---------------------------------------------------------------
	// registers
	// ---------------------------------------------------------------
	always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			r <= RESET_VAL;
		end else begin
			r <= next_r;
		end
	end

	// ---------------------------------------------------------------
	// outputs
	// ---------------------------------------------------------------
	assign BUS.host_grant_n_o = r.grant_n;
	assign BUS.host_grant_n_oe = r.grant_oe;
	assign BUS.host_ack_o = r.ack;
	assign BUS.host_ack_oe = r.ack_oe;
	assign BUS.mp_request_n_o = r.req_o;
	assign BUS.mp_request_n_oe = r.req_oe;
	assign EXT_ACCESS_DONE_OUT = r.done;
	assign BUS_DRIVE_EN_OUT = r.drive;
	assign BUS_MASTER_OUT = r.master;
	assign HOST_GRANTED_OUT = r.granted;
endmodule : hmbo_device
`default_nettype wire

// *** verilog/hmbo_host.sv ***
`timescale 1ns/1ns
`default_nettype none
module hmbo_host
	import hmbo_pkg::*;
(
	input wire logic CLK_SYS_IN,
	input wire logic RST_N_IN,
	hmbo_if.host BUS,
	input wire logic BUS_WANT_IN,
	input wire logic SELECT_IN,
	input wire logic RECOVER_IN,
	output logic BUS_OWNED_OUT,
	output logic WAITING_OUT
);
	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	typedef struct packed {
		logic [1:0] g_sync;
		logic [1:0] a_sync;
		logic req_n;
		logic sel_n;
		logic sb_n;
		logic owned;
		logic wait_s;
	} hmbo_host_t;

	hmbo_host_t r;
	hmbo_host_t next_r;

	always_comb begin
		next_r = r;
		next_r.g_sync = {r.g_sync[0], BUS.host_grant_n};
		next_r.a_sync = {r.a_sync[0], BUS.host_ack};
		next_r.req_n = !BUS_WANT_IN;
		next_r.sel_n = !(SELECT_IN && r.owned);
		next_r.sb_n = !RECOVER_IN;
		next_r.owned = BUS_WANT_IN && !r.g_sync[1];
		next_r.wait_s = !r.sel_n && !r.a_sync[1];
	end

	always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			r <= '{g_sync: 2'h3, a_sync: 2'h3, req_n: 1'b1, sel_n: 1'b1,
				sb_n: 1'b1, owned: 1'b0, wait_s: 1'b0};
		end else begin
			r <= next_r;
		end
	end

	assign BUS.host_request_n = r.req_n;
	assign BUS.host_select_n = r.sel_n;
	assign BUS.suspend_bus_float_n = r.sb_n;
	assign BUS_OWNED_OUT = r.owned;
	assign WAITING_OUT = r.wait_s;
endmodule : hmbo_host
`default_nettype wire

// *** test/hmbo_properties.sv ***
`timescale 1ns/1ns
`default_nettype none
module hmbo_properties
	import hmbo_pkg::*;
(
	input wire logic CLK_SYS_IN,
	input wire logic RST_N_IN,
	input wire logic host_request_n,
	input wire logic host_select_n,
	input wire logic host_grant_n,
	input wire logic host_ack_oe,
	input wire logic [NUM_PROC-1:0] mp_request_n_oe
);
	// ----------------------------------------
	// ownership and acknowledge properties
	// ----------------------------------------
	default clocking cb @(posedge CLK_SYS_IN); endclocking
	default disable iff (!RST_N_IN);
	a_grant_hold: assert property (
		!host_grant_n && !host_request_n |=> !host_grant_n)
		else $error("grant dropped during request");
	a_grant_cause: assert property (
		$fell(host_grant_n) |-> !host_request_n && !$past(host_request_n, 3))
		else $error("grant without request");
	a_grant_release: assert property (
		$rose(host_request_n) |-> ##[1:6] host_grant_n)
		else $error("grant not released");
	a_grant_quiet: assert property (
		host_request_n [*6] |-> host_grant_n)
		else $error("grant while idle");
	// inputs pass two flops, so allow that lag
	a_ack_select: assert property (
		host_select_n [*6] |-> !host_ack_oe)
		else $error("ack driven without select");
	a_ack_request: assert property (
		host_request_n [*6] |-> !host_ack_oe)
		else $error("ack driven without request");
	a_one_line: assert property (
		$onehot0(mp_request_n_oe))
		else $error("several request lines driven");
	a_line_fixed: assert property (
		$onehot(mp_request_n_oe) |=> mp_request_n_oe == 6'h00
		|| mp_request_n_oe == $past(mp_request_n_oe))
		else $error("request line moved");
endmodule : hmbo_properties
`default_nettype wire

// *** test/tb_top.sv ***
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	import hmbo_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [IDX_W-1:0] idx = 3'h0;
	logic ext_req = 1'b1, hwait = 1'b0;
	logic want = 1'b0, sel = 1'b0, recover = 1'b0;
	logic rot = 1'b0, adrv = 1'b0;
	logic done, drv, master, granted, owned, waiting;
	logic [NUM_PROC-1:0] seen;
	logic [NUM_PROC-1:0] line_tab [7] = '{6'h00, 6'h01, 6'h02,
		6'h04, 6'h08, 6'h10, 6'h20};
	int err_count = 0;
	int compares = 0;
	always #50 clk = ~clk;
	hmbo_if bus_if();
	// one device only: rotation has no rival, so only its decode is reached
	hmbo_device u_hmbo_device(.CLK_SYS_IN(clk), .RST_N_IN(rst_n),
		.BUS(bus_if.device), .PROCESSOR_INDEX_IN(idx),
		.ROTATING_PRIORITY_SEL_IN(rot), .ACK_ACTIVE_DRIVE_IN(adrv),
		.EXT_ACCESS_REQ_IN(ext_req), .HOST_WAIT_IN(hwait),
		.EXT_ACCESS_DONE_OUT(done), .BUS_DRIVE_EN_OUT(drv),
		.BUS_MASTER_OUT(master), .HOST_GRANTED_OUT(granted));
	hmbo_host u_hmbo_host(.CLK_SYS_IN(clk), .RST_N_IN(rst_n),
		.BUS(bus_if.host), .BUS_WANT_IN(want), .SELECT_IN(sel),
		.RECOVER_IN(recover), .BUS_OWNED_OUT(owned), .WAITING_OUT(waiting));
	hmbo_properties u_hmbo_properties(.CLK_SYS_IN(clk), .RST_N_IN(rst_n),
		.host_request_n(bus_if.host_request_n),
		.host_select_n(bus_if.host_select_n),
		.host_grant_n(bus_if.host_grant_n),
		.host_ack_oe(bus_if.host_ack_oe),
		.mp_request_n_oe(bus_if.mp_request_n_oe));
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic tally_and_finish();
		$display("compares %0d err_count %0d", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : tally_and_finish
	task automatic chk(input logic [5:0] got, exp, input string m);
		compares++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected at %0t: %s", $time, m);
		end
	endtask : chk
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#5;
	endtask : step
	function automatic logic probe(input int s);
		case (s)
			0: return master;
			1: return bus_if.host_grant_n;
			2: return bus_if.host_ack;
			3: return drv;
			default: return done;
		endcase
	endfunction : probe
	task automatic wait_for(input int s, input logic v, input string m);
		for (int n = 0; n < 20 && probe(s) !== v; n++)
			step(1);
		chk(6'(probe(s)), 6'(v), m);
		if (probe(s) !== v)
			tally_and_finish();
	endtask : wait_for
	initial begin
		for (int i = 0; i < 7; i++) begin
			rst_n = 1'b0;
			idx = 3'(i);
			step(10);
			rst_n = 1'b1;
			seen = 6'h00;
			repeat (8) begin
				step(1);
				seen = seen | ~bus_if.mp_request_n;
			end
			chk(seen, line_tab[i], "request line");
			wait_for(0, 1'b1, "no mastership");
			$display("index %0d done", i);
		end
		want = 1'b1;
		wait_for(1, 1'b0, "no grant");
		step(3);
		chk(6'(drv), 6'h00, "bus still driven");
		chk(6'({granted, owned}), 6'h03, "host not owner");
		sel = 1'b1;
		hwait = 1'b1;
		wait_for(2, 1'b0, "no wait state");
		step(3);
		chk(6'(waiting), 6'h01, "host not waiting");
		hwait = 1'b0;
		step(6);
		chk(6'(bus_if.host_ack_oe), 6'h00, "ack not open drain");
		sel = 1'b0;
		hwait = 1'b1;
		step(6);
		chk(6'(bus_if.host_ack_oe), 6'h00, "ack w/o select");
		hwait = 1'b0;
		step(10);
		chk(6'(bus_if.host_grant_n), 6'h00, "grant lost");
		chk(6'(drv), 6'h00, "processor took bus");
		want = 1'b0;
		wait_for(1, 1'b1, "grant kept");
		wait_for(3, 1'b1, "no bus resume");
		$display("host takeover done");
		recover = 1'b1;
		wait_for(3, 1'b0, "bus not floated");
		step(5);
		chk(6'({done, master}), 6'h01, "access not stalled");
		recover = 1'b0;
		wait_for(4, 1'b1, "access not resumed");
		$display("suspend done");
		// modes change only while reset is held
		rst_n = 1'b0;
		rot = 1'b1;
		adrv = 1'b1;
		step(10);
		rst_n = 1'b1;
		wait_for(0, 1'b1, "no rotating mastership");
		want = 1'b1;
		wait_for(1, 1'b0, "no grant in rotating mode");
		step(3);
		sel = 1'b1;
		step(6);
		chk(6'({bus_if.host_ack_oe, bus_if.host_ack}), 6'h03, "ack not driven");
		sel = 1'b0;
		want = 1'b0;
		step(8);
		chk(6'(bus_if.host_ack_oe), 6'h00, "ack left driven");
		$display("active drive done");
		tally_and_finish();
	end
endmodule : tb_top
`default_nettype wire
